// file: design/tfec_defines.svh
// constants for the transmit fec encoder and interleaver
`ifndef TFEC_DEFINES_SVH
`define TFEC_DEFINES_SVH

`define TFEC_BCH_N 63
`define TFEC_BCH_K 51
`define TFEC_PAR_W 12
`define TFEC_GEN_LOW 12'h539
`define TFEC_DMAX 5
`define TFEC_M_MAX 5
`define TFEC_SPC_DATA 8
`define TFEC_ROWS_MAX 5
`define TFEC_FIFO_DEPTH 4

`endif

// file: design/tfec_pkg.sv
// types for the transmit fec encoder and interleaver
package tfec_pkg;
    typedef enum logic {
        TFEC_FEC_BCH,
        TFEC_FEC_SPC
    } tfec_fec_t;

    typedef enum logic [3:0] {
        TFEC_IDLE,
        TFEC_CALC_MB,
        TFEC_CALC_K,
        TFEC_BCH_MSG,
        TFEC_BCH_PAR,
        TFEC_DRAIN,
        TFEC_SPC_DATA,
        TFEC_SPC_PAR,
        TFEC_FLUSH,
        TFEC_DONE
    } tfec_state_t;
endpackage

// file: design/tfec_fifo.sv
// small synchronous fifo with valid and ready on both sides
module tfec_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_size_check
        $error("tfec_fifo: depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;

    assign next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
    assign next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
    assign rd_valid_out = wr_ptr != rd_ptr;
    assign rd_data_out = mem[rd_ptr[AW-1:0]];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            wr_ready_out <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            // registered flag, so the writer sees no path from the read side
            wr_ready_out <= (next_wr_ptr - next_rd_ptr) != (AW+1)'(DEPTH);
        end
    end
endmodule

// file: design/tfec_encoder.sv
// transmit fec: shortened bch with block interleaver, or (9,8) parity-check over m-bit symbols
//
// What this block does
// - each packet uses exactly one method, bch or parity-check, latched at start
// - the chosen method is driven out for the physical layer header
// - only the bch path goes through the bit interleaver
// - parity-check groups bits into symbols before coding; bch groups after interleaving
// - bch path uses shortened (63,51) code, generator 1+x3+x4+x5+x8+x10+x12
// - parity is remainder of x^12 times message over generator, via lfsr
// - message block count is payload length over 51, rounded up
// - block length k is payload length over block count, rounded up
// - shortening is 51 minus k; coded block length is 63 minus shortening
// - payload is zero padded to block count times k bits
// - each k-bit message block is followed by its 12 parity bits
// - shortening length must lie from 1 to 50
// - every 8 m-bit data symbols gain one parity symbol, nine in all
// - parity symbol is the field sum of the eight data symbols
// - parity-check payload is zero padded up to whole blocks of 8m bits
// - interleaver writes d codewords row-wise, reads column-wise, serial out
// - initial interleaver depth equals symbol size m
// - residual depth, interleave block count and depth limit 5 are derived
// - zero residual: every interleave block has depth d
// - nonzero residual, fewer codewords than d: depth is the residual
// - fits limit: depth d blocks, then one block of d plus residual
// - over limit: depth d blocks, then ceiling and floor halves of d plus residual
// - the output stream is packed into consecutive m-bit symbols
`include "tfec_defines.svh"

module tfec_encoder #(
    parameter int LEN_W = 16
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic fec_spc_in,
    input wire logic [2:0] sym_size_in,
    input wire logic [LEN_W-1:0] payload_bit_length_in,
    input wire logic bit_in,
    input wire logic bit_valid_in,
    output logic bit_ready_out,
    output logic [`TFEC_M_MAX-1:0] sym_out,
    output logic sym_valid_out,
    input wire logic sym_ready_in,
    output logic hdr_fec_spc_out,
    output logic busy_out,
    output logic done_out,
    output logic cfg_err_out,
    output logic [5:0] short_len_out
);
    if (LEN_W < 7 || LEN_W > 24) begin : g_len_check
        $error("tfec_encoder: LEN_W out of range");
    end

    localparam int MEM_BITS = `TFEC_ROWS_MAX * `TFEC_BCH_N;
    localparam int IDX_W = $clog2(MEM_BITS);

    ////////////////////////////////////////////////////////////////////////
    logic f_data, f_valid, f_ready, f_wr_ready;

    tfec_fifo #(
        .WIDTH(1),
        .DEPTH(`TFEC_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .wr_data_in(bit_in),
        .wr_valid_in(bit_valid_in),
        .wr_ready_out(f_wr_ready),
        .rd_data_out(f_data),
        .rd_valid_out(f_valid),
        .rd_ready_in(f_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    tfec_pkg::tfec_state_t st;
    tfec_pkg::tfec_fec_t fec;
    logic [LEN_W-1:0] len, taken, mb, nb, ib, cw_cnt;
    logic [LEN_W+6:0] acc;
    logic [5:0] k, col, rcol, n_len;
    logic [2:0] m_sz, dr, depth, row, rrow, pk_cnt;
    logic [`TFEC_PAR_W-1:0] par;
    logic [3:0] spc_cnt;
    logic [`TFEC_M_MAX-1:0] spc_acc, pk_sh, sym_val;
    logic il_mem [0:MEM_BITS-1];
    logic out_free, need_fifo, adv, cur_bit, push, push_bit, sym_load, pk_full, start_ok;

    assign bit_ready_out = f_wr_ready;
    assign out_free = !sym_valid_out || sym_ready_in;
    assign n_len = k + 6'(`TFEC_PAR_W);
    assign pk_full = pk_cnt == m_sz - 3'd1;
    assign start_ok = sym_size_in != 3'd0 && sym_size_in <= 3'(`TFEC_M_MAX)
        && payload_bit_length_in != '0;

    // depth of interleave block b
    function automatic logic [2:0] blk_depth(input logic [LEN_W-1:0] b);
        logic [3:0] sum;
        sum = {1'b0, m_sz} + {1'b0, dr};
        blk_depth = m_sz;
        if (dr == 3'd0) begin
            blk_depth = m_sz;
        end else if (mb < LEN_W'(m_sz)) begin
            blk_depth = dr;
        end else if (sum <= 4'(`TFEC_DMAX)) begin
            if (b == nb - LEN_W'(2)) begin
                blk_depth = sum[2:0];
            end
        end else if (b == nb - LEN_W'(2)) begin
            blk_depth = 3'((sum + 4'd1) >> 1);
        end else if (b == nb - LEN_W'(1)) begin
            blk_depth = 3'(sum >> 1);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bit source: payload from fifo, zeros once the payload is used up
    always_comb begin
        need_fifo = 1'b0;
        if (st == tfec_pkg::TFEC_BCH_MSG || st == tfec_pkg::TFEC_SPC_DATA) begin
            need_fifo = taken < len;
        end
    end

    assign cur_bit = need_fifo ? f_data : 1'b0;

    always_comb begin
        adv = 1'b0;
        unique case (st)
            tfec_pkg::TFEC_BCH_MSG: adv = !need_fifo || f_valid;
            tfec_pkg::TFEC_BCH_PAR: adv = 1'b1;
            tfec_pkg::TFEC_SPC_DATA: adv = out_free && (!need_fifo || f_valid);
            tfec_pkg::TFEC_DRAIN, tfec_pkg::TFEC_SPC_PAR, tfec_pkg::TFEC_FLUSH: adv = out_free;
            default: adv = 1'b0;
        endcase
    end

    assign f_ready = adv && need_fifo;

    ////////////////////////////////////////////////////////////////////////
    // feed to symbol packer and output register
    always_comb begin
        push = 1'b0;
        push_bit = 1'b0;
        sym_load = 1'b0;
        sym_val = pk_sh;
        unique case (st)
            tfec_pkg::TFEC_SPC_DATA: begin
                push = adv;
                push_bit = cur_bit;
            end
            tfec_pkg::TFEC_DRAIN: begin
                push = adv;
                push_bit = il_mem[IDX_W'(rrow) * IDX_W'(`TFEC_BCH_N) + IDX_W'(rcol)];
            end
            tfec_pkg::TFEC_FLUSH: begin
                push = adv && pk_cnt != 3'd0;
            end
            tfec_pkg::TFEC_SPC_PAR: begin
                sym_load = adv;
                sym_val = spc_acc;
            end
            default: push = 1'b0;
        endcase
        if (push && pk_full) begin
            sym_load = 1'b1;
            sym_val[pk_cnt] = push_bit;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || st == tfec_pkg::TFEC_IDLE) begin
            pk_sh <= '0;
            pk_cnt <= 3'd0;
        end else if (push) begin
            if (pk_full) begin
                pk_sh <= '0;
                pk_cnt <= 3'd0;
            end else begin
                pk_sh[pk_cnt] <= push_bit;
                pk_cnt <= pk_cnt + 3'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            sym_out <= '0;
            sym_valid_out <= 1'b0;
        end else if (sym_load) begin
            sym_out <= sym_val;
            sym_valid_out <= 1'b1;
        end else if (sym_ready_in) begin
            sym_valid_out <= 1'b0;
        end
    end

    // parity-check accumulation per group of eight
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || st == tfec_pkg::TFEC_IDLE) begin
            spc_acc <= '0;
            spc_cnt <= 4'd0;
        end else if (st == tfec_pkg::TFEC_SPC_PAR && adv) begin
            spc_acc <= '0;
            spc_cnt <= 4'd0;
        end else if (st == tfec_pkg::TFEC_SPC_DATA && sym_load) begin
            spc_acc <= spc_acc ^ sym_val;
            spc_cnt <= spc_cnt + 4'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bch lfsr and interleaver array
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || st == tfec_pkg::TFEC_IDLE) begin
            par <= '0;
        end else if (st == tfec_pkg::TFEC_BCH_MSG && adv) begin
            // feedback form divides x^12 m(x) by the generator
            if (cur_bit ^ par[`TFEC_PAR_W-1]) begin
                par <= {par[`TFEC_PAR_W-2:0], 1'b0} ^ `TFEC_GEN_LOW;
            end else begin
                par <= {par[`TFEC_PAR_W-2:0], 1'b0};
            end
        end else if (st == tfec_pkg::TFEC_BCH_PAR) begin
            par <= {par[`TFEC_PAR_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (st == tfec_pkg::TFEC_BCH_MSG && adv) begin
            il_mem[IDX_W'(row) * IDX_W'(`TFEC_BCH_N) + IDX_W'(col)] <= cur_bit;
        end else if (st == tfec_pkg::TFEC_BCH_PAR) begin
            il_mem[IDX_W'(row) * IDX_W'(`TFEC_BCH_N) + IDX_W'(col)] <= par[`TFEC_PAR_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packet sequencer
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            st <= tfec_pkg::TFEC_IDLE;
            fec <= tfec_pkg::TFEC_FEC_BCH;
            m_sz <= 3'd1;
            len <= '0;
            taken <= '0;
            mb <= '0;
            nb <= '0;
            ib <= '0;
            cw_cnt <= '0;
            acc <= '0;
            k <= 6'd0;
            dr <= 3'd0;
            depth <= 3'd1;
            row <= 3'd0;
            col <= 6'd0;
            rrow <= 3'd0;
            rcol <= 6'd0;
        end else begin
            if (f_ready) begin
                taken <= taken + LEN_W'(1);
            end
            unique case (st)
                tfec_pkg::TFEC_IDLE: begin
                    taken <= '0;
                    mb <= '0;
                    nb <= '0;
                    ib <= '0;
                    cw_cnt <= '0;
                    acc <= '0;
                    k <= 6'd0;
                    dr <= 3'd0;
                    row <= 3'd0;
                    col <= 6'd0;
                    if (start_in && start_ok) begin
                        fec <= fec_spc_in ? tfec_pkg::TFEC_FEC_SPC : tfec_pkg::TFEC_FEC_BCH;
                        m_sz <= sym_size_in;
                        len <= payload_bit_length_in;
                        st <= fec_spc_in ? tfec_pkg::TFEC_SPC_DATA : tfec_pkg::TFEC_CALC_MB;
                    end
                end
                tfec_pkg::TFEC_CALC_MB: begin
                    if (acc >= (LEN_W+7)'(len)) begin
                        acc <= '0;
                        st <= tfec_pkg::TFEC_CALC_K;
                    end else begin
                        acc <= acc + (LEN_W+7)'(`TFEC_BCH_K);
                        mb <= mb + LEN_W'(1);
                        if (dr == 3'd0) begin
                            nb <= nb + LEN_W'(1);
                        end
                        dr <= (dr == m_sz - 3'd1) ? 3'd0 : dr + 3'd1;
                    end
                end
                tfec_pkg::TFEC_CALC_K: begin
                    if (acc >= (LEN_W+7)'(len)) begin
                        depth <= blk_depth('0);
                        st <= tfec_pkg::TFEC_BCH_MSG;
                    end else begin
                        acc <= acc + (LEN_W+7)'(mb);
                        k <= k + 6'd1;
                    end
                end
                tfec_pkg::TFEC_BCH_MSG: begin
                    if (adv) begin
                        col <= col + 6'd1;
                        if (col == k - 6'd1) begin
                            st <= tfec_pkg::TFEC_BCH_PAR;
                        end
                    end
                end
                tfec_pkg::TFEC_BCH_PAR: begin
                    if (col == n_len - 6'd1) begin
                        col <= 6'd0;
                        cw_cnt <= cw_cnt + LEN_W'(1);
                        if (row == depth - 3'd1 || cw_cnt + LEN_W'(1) == mb) begin
                            rrow <= 3'd0;
                            rcol <= 6'd0;
                            st <= tfec_pkg::TFEC_DRAIN;
                        end else begin
                            row <= row + 3'd1;
                            st <= tfec_pkg::TFEC_BCH_MSG;
                        end
                    end else begin
                        col <= col + 6'd1;
                    end
                end
                tfec_pkg::TFEC_DRAIN: begin
                    if (adv) begin
                        // column-major read of the filled rows
                        if (rrow == row) begin
                            rrow <= 3'd0;
                            rcol <= rcol + 6'd1;
                            if (rcol == n_len - 6'd1) begin
                                row <= 3'd0;
                                ib <= ib + LEN_W'(1);
                                depth <= blk_depth(ib + LEN_W'(1));
                                st <= (cw_cnt == mb) ? tfec_pkg::TFEC_FLUSH : tfec_pkg::TFEC_BCH_MSG;
                            end
                        end else begin
                            rrow <= rrow + 3'd1;
                        end
                    end
                end
                tfec_pkg::TFEC_SPC_DATA: begin
                    if (sym_load && spc_cnt == 4'(`TFEC_SPC_DATA - 1)) begin
                        st <= tfec_pkg::TFEC_SPC_PAR;
                    end
                end
                tfec_pkg::TFEC_SPC_PAR: begin
                    if (adv) begin
                        st <= (taken >= len) ? tfec_pkg::TFEC_DONE : tfec_pkg::TFEC_SPC_DATA;
                    end
                end
                tfec_pkg::TFEC_FLUSH: begin
                    // a bch stream that is not a whole number of symbols ends zero filled
                    if (adv && (pk_cnt == 3'd0 || pk_full)) begin
                        st <= tfec_pkg::TFEC_DONE;
                    end
                end
                tfec_pkg::TFEC_DONE: begin
                    st <= tfec_pkg::TFEC_IDLE;
                end
                default: st <= tfec_pkg::TFEC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            hdr_fec_spc_out <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            if (st == tfec_pkg::TFEC_IDLE && start_in && start_ok) begin
                hdr_fec_spc_out <= fec_spc_in;
            end
            busy_out <= st != tfec_pkg::TFEC_IDLE && st != tfec_pkg::TFEC_DONE;
            done_out <= st == tfec_pkg::TFEC_DONE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cfg_err_out <= 1'b0;
            short_len_out <= 6'd0;
        end else if (st == tfec_pkg::TFEC_IDLE && start_in) begin
            cfg_err_out <= !start_ok;
            short_len_out <= 6'd0;
        end else if (st == tfec_pkg::TFEC_CALC_K && acc >= (LEN_W+7)'(len)) begin
            short_len_out <= 6'(`TFEC_BCH_K) - k;
            // unshortened block (k of 51) lies outside the permitted range
            cfg_err_out <= k == 6'(`TFEC_BCH_K) || k == 6'd0;
        end
    end
endmodule

// file: test/tfec_encoder_props.sv
// port checker for the fec encoder, bound at the foot
`include "tfec_defines.svh"
module tfec_encoder_props #(
    parameter int LEN_W = 16
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic fec_spc_in,
    input wire logic [2:0] sym_size_in,
    input wire logic [LEN_W-1:0] payload_bit_length_in,
    input wire logic bit_in,
    input wire logic bit_valid_in,
    input wire logic bit_ready_out,
    input wire logic [`TFEC_M_MAX-1:0] sym_out,
    input wire logic sym_valid_out,
    input wire logic sym_ready_in,
    input wire logic hdr_fec_spc_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic cfg_err_out,
    input wire logic [5:0] short_len_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    logic go;
    logic bad;
    // busy lags the state by one cycle, so a start right after another is left out
    assign go = start_in && !busy_out && !done_out;
    assign bad = sym_size_in == 3'h0 || sym_size_in > 3'h5 || payload_bit_length_in == '0;
    ////////////////////////////////////////////////////////////////
    property p_err;
        go && bad && !$past(start_in) |=> (cfg_err_out && !busy_out) [*2];
    endproperty
    a_err: assert property (p_err) else $error("bad setting not refused");
    property p_go;
        go && !bad && !$past(start_in) && !$past(done_out) |=> ##[0:2] busy_out;
    endproperty
    a_go: assert property (p_go) else $error("legal start not taken");
    property p_hdr;
        busy_out && $past(busy_out) |-> $stable(hdr_fec_spc_out);
    endproperty
    a_hdr: assert property (p_hdr) else $error("method changed in packet");
    property p_spc;
        busy_out && $past(busy_out) && hdr_fec_spc_out |-> short_len_out == 6'h00;
    endproperty
    a_spc: assert property (p_spc) else $error("shortening on parity path");
    property p_rng;
        sym_valid_out && busy_out && !hdr_fec_spc_out && !cfg_err_out |-> short_len_out inside {[6'h01:6'h32]};
    endproperty
    a_rng: assert property (p_rng) else $error("shortening out of range");
    property p_hold;
        sym_valid_out && !sym_ready_in |=> sym_valid_out && $stable(sym_out);
    endproperty
    a_hold: assert property (p_hold) else $error("symbol not held");
    property p_pulse;
        done_out |=> !done_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_dbusy;
        done_out |-> $past(busy_out);
    endproperty
    a_dbusy: assert property (p_dbusy) else $error("done without packet");
endmodule
////////////////////////////////////////////////////////////////
bind tfec_encoder tfec_encoder_props #(.LEN_W(LEN_W)) i_tfec_encoder_props (.*);

// file: test/tfec_sink.sv
// downstream symbol sink, prompt or stalling at random
`include "tfec_defines.svh"
module tfec_sink (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [`TFEC_M_MAX-1:0] sym_in,
    input wire logic sym_valid_in,
    input wire logic stall_in,
    output logic sym_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`TFEC_M_MAX-1:0] got[$];
    initial sym_ready_out = 1'b0;
    // random stalls make the encoder hold its symbol
    always @(posedge clk_sys_in) begin
        if (resetn_in && sym_valid_in && sym_ready_out) begin
            got.push_back(sym_in);
        end
        sym_ready_out <= !stall_in || ($urandom % 3 == 0);
    end
endmodule

// file: test/tfec_encoder_tb.sv
// self-checking bench for the fec encoder
`include "tfec_defines.svh"
module tfec_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic start_in = 1'b0;
    logic fec_spc_in = 1'b0;
    logic bit_in = 1'b0;
    logic bit_valid_in = 1'b0;
    logic stall = 1'b0;
    logic [2:0] sym_size_in = 3'h1;
    logic [15:0] payload_bit_length_in = 16'h0000;
    logic bit_ready_out, sym_valid_out, sym_ready_in, hdr_fec_spc_out, busy_out, done_out, cfg_err_out;
    logic [`TFEC_M_MAX-1:0] sym_out;
    logic [5:0] short_len_out;
    int failures = 0;
    int tests_run = 0;
    int fed, kk;
    bit pay[$];
    int expq[$];
    int bm[7] = '{1, 3, 3, 2, 4, 5, 2};
    int bl[7] = '{40, 130, 60, 250, 350, 300, 102};
    always #12.5 clk_sys_in = ~clk_sys_in;
    tfec_encoder #(.LEN_W(16)) i_tfec_encoder (.*);
    tfec_sink i_tfec_sink (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sym_in(sym_out),
        .sym_valid_in(sym_valid_out), .stall_in(stall), .sym_ready_out(sym_ready_in));
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic guard(input bit ok);
        if (!ok) begin
            failures++;
            print_verdict;
        end
    endtask
    task automatic feed(input int len);
        int t;
        logic r;
        for (int i = 0; i < len; i++) begin
            bit_valid_in <= 1'b1;
            bit_in <= pay[i];
            t = 0;
            do begin
                @(negedge clk_sys_in);
                r = bit_ready_out;
                @(posedge clk_sys_in);
                t++;
            end while (r !== 1'b1 && t < 30000);
            guard(t < 30000);
            fed++;
        end
        bit_valid_in <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic model(input bit single_parity_check_path, input int m, input int len);
        int mb, n, sym, c, nb;
        int dep[$];
        bit s[$];
        bit cw[$];
        logic [11:0] r;
        bit b;
        kk = 0;
        if (single_parity_check_path) begin
            mb = (len + 8 * m - 1) / (8 * m);
            for (int g = 0; g < mb; g++) begin
                c = 0;
                for (int j = 0; j < 8; j++) begin
                    sym = 0;
                    for (int i = 0; i < m; i++) begin
                        n = (g * 8 + j) * m + i;
                        if (n < len && pay[n]) sym |= 1 << i;
                    end
                    expq.push_back(sym);
                    c ^= sym;
                end
                expq.push_back(c);
            end
            return;
        end
        mb = (len + 50) / 51;
        kk = (len + mb - 1) / mb;
        n = kk + 12;
        for (int g = 0; g < mb; g++) begin
            r = 12'h000;
            for (int i = 0; i < kk; i++) begin
                b = (g * kk + i < len) ? pay[g * kk + i] : 1'b0;
                cw.push_back(b);
                r = {r[10:0], 1'b0} ^ ((b ^ r[11]) ? `TFEC_GEN_LOW : 12'h000);
            end
            for (int i = 11; i >= 0; i--) cw.push_back(r[i]);
        end
        c = mb % m;
        nb = (mb + m - 1) / m;
        if (c == 0) repeat (nb) dep.push_back(m);
        else if (mb < m) dep.push_back(c);
        else begin
            repeat (nb - 2) dep.push_back(m);
            if (m + c <= 5) dep.push_back(m + c);
            else begin
                dep.push_back((m + c + 1) / 2);
                dep.push_back((m + c) / 2);
            end
        end
        c = 0;
        foreach (dep[x]) begin
            for (int col = 0; col < n; col++) begin
                for (int row = 0; row < dep[x]; row++) s.push_back(cw[(c + row) * n + col]);
            end
            c += dep[x];
        end
        for (int i = 0; i < s.size(); i += m) begin
            sym = 0;
            for (int j = 0; j < m; j++) if (i + j < s.size() && s[i + j]) sym |= 1 << j;
            expq.push_back(sym);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic run_pkt(input bit single_parity_check_path, input int m, input int len, input bit pre);
        int t;
        pay.delete();
        expq.delete();
        i_tfec_sink.got.delete();
        repeat (len) pay.push_back(1'($urandom));
        model(single_parity_check_path, m, len);
        @(posedge clk_sys_in);
        stall <= 1'($urandom);
        fed = 0;
        fork
            feed(len);
        join_none
        if (pre) begin
            // bits wait in the fifo before start, so it fills and refuses
            repeat (8) @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            check({15'h0, bit_ready_out}, 16'h0000);
            check(16'(fed), 16'(`TFEC_FIFO_DEPTH));
        end
        @(posedge clk_sys_in);
        start_in <= 1'b1;
        fec_spc_in <= single_parity_check_path;
        sym_size_in <= 3'(m);
        payload_bit_length_in <= 16'(len);
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        // a second start with the other method must be ignored
        start_in <= 1'b1;
        fec_spc_in <= !single_parity_check_path;
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        t = 0;
        do begin
            @(negedge clk_sys_in);
            t++;
        end while (done_out !== 1'b1 && t < 30000);
        guard(t < 30000);
        check({15'h0, hdr_fec_spc_out}, {15'h0, single_parity_check_path});
        check({15'h0, cfg_err_out}, {15'h0, !single_parity_check_path && kk == 51});
        check({10'h0, short_len_out}, single_parity_check_path ? 16'h0000 : 16'(51 - kk));
        t = 0;
        while (i_tfec_sink.got.size() < expq.size() && t < 30000) begin
            @(negedge clk_sys_in);
            t++;
        end
        guard(t < 30000);
        repeat (3) @(negedge clk_sys_in);
        check(16'(i_tfec_sink.got.size()), 16'(expq.size()));
        foreach (expq[i]) check({11'h0, i_tfec_sink.got[i]}, 16'(expq[i]));
        check({14'h0, sym_valid_out, bit_ready_out}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hA304));
        repeat (6) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in);
            start_in <= 1'b1;
            sym_size_in <= (i == 3) ? 3'h2 : ((i == 0) ? 3'h0 : 3'(5 + i));
            payload_bit_length_in <= (i == 3) ? 16'h0000 : 16'h0005;
            @(posedge clk_sys_in);
            start_in <= 1'b0;
            @(negedge clk_sys_in);
            check({14'h0, cfg_err_out, busy_out}, 16'h0002);
        end
        for (int m = 1; m <= 5; m++) run_pkt(1'b1, m, 1 + $urandom % 60, m == 1);
        foreach (bm[i]) run_pkt(1'b0, bm[i], bl[i], 1'b0);
        repeat (3) run_pkt(1'($urandom), 1 + $urandom % 5, 1 + $urandom % 200, 1'b0);
        print_verdict;
    end
endmodule
